/* File: cal_pkg.sv */
`default_nettype none
package cal_pkg;
	// Widths of the program counter and the data bytes, and the return stack depth.
	localparam int PC_W = 12;
	localparam int DATA_W = 8;
	localparam int STACK_DEPTH = 6;

	// Data-space locations that live inside the core, and the reset address.
	localparam logic [7:0] ADDR_SHORT_BASE = 8'h80;
	localparam logic [7:0] ADDR_ACC = 8'hff;
	localparam logic [PC_W-1:0] RESET_PC = 12'h000;

	// Opcode groups, taken from the upper nibble (or upper three bits).
	localparam logic [3:0] OPG_SHORT = 4'h8;
	localparam logic [3:0] OPG_JUMP = 4'h9;
	localparam logic [3:0] OPG_BIT = 4'ha;
	localparam logic [3:0] OPG_BTB = 4'hb;
	localparam logic [2:0] OPG_IND = 3'h6;
	localparam logic [3:0] OPG_MISC = 4'he;
	localparam logic [3:0] OPG_CALL = 4'hf;

	// Low nibble of the miscellaneous group.
	localparam logic [3:0] SUB_DLOAD = 4'h0;
	localparam logic [3:0] SUB_DSTORE = 4'h1;
	localparam logic [3:0] SUB_LDI_ACC = 4'h2;
	localparam logic [3:0] SUB_LDI_MEM = 4'h3;
	localparam logic [3:0] SUB_RET = 4'h4;

	// Relative branch test types in opcode bits 6 and 5.
	localparam logic [1:0] COND_NZ = 2'h0;
	localparam logic [1:0] COND_NC = 2'h1;
	localparam logic [1:0] COND_Z = 2'h2;
	localparam logic [1:0] COND_C = 2'h3;

	// Cycles per instruction class.
	localparam logic [2:0] CYC_LS = 3'h4;
	localparam logic [2:0] CYC_BR = 3'h2;
	localparam logic [2:0] CYC_BTB = 3'h5;
	localparam logic [2:0] CYC_BIT = 3'h4;
	localparam logic [2:0] CYC_JMP = 3'h4;
	localparam logic [2:0] CYC_CTL = 3'h2;

	typedef enum logic [3:0] {
		CLS_BR, CLS_SHORT, CLS_JUMP, CLS_CALL, CLS_BIT, CLS_BTB, CLS_IND,
		CLS_DLOAD, CLS_DSTORE, CLS_LDI_ACC, CLS_LDI_MEM, CLS_RET, CLS_NOP
	} cal_cls_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic we;
	} cal_dm_req_t;

	typedef struct packed {
		logic zero;
		logic carry;
	} cal_flags_t;
endpackage : cal_pkg
`default_nettype wire

/* File: cal_stack_mem.sv */
`default_nettype none
// Return-address cells with one write port and a registered read port.
module cal_stack_mem #(
	parameter int DEPTH = 6,
	parameter int WIDTH = 12
) (
	input wire logic clock,
	input wire logic ce,
	input wire logic we,
	input wire logic [2:0] waddr,
	input wire logic [WIDTH-1:0] wdata,
	input wire logic [2:0] raddr,
	output logic [WIDTH-1:0] rdata
);
	logic [WIDTH-1:0] cell_q [DEPTH];

	// Cells are written only when the clock enable is high.
	always_ff @(posedge clock) begin
		if (ce && we) begin
			cell_q[waddr] <= wdata;
		end
	end

	// Read data come out of a register one cycle after the address.
	always_ff @(posedge clock) begin
		if (ce) begin
			rdata <= cell_q[raddr];
		end
	end
endmodule : cal_stack_mem
`default_nettype wire

/* File: cal_core.sv */
`default_nettype none
module cal_core (
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	input wire logic [7:0] pm_rdata,
	output logic [cal_pkg::PC_W-1:0] pm_addr_q,
	input wire logic [7:0] dm_rdata,
	output cal_pkg::cal_dm_req_t dm_req_q,
	output logic [7:0] acc_q,
	output cal_pkg::cal_flags_t flags_q,
	output logic retire_q
);
	import cal_pkg::*;

	logic [2:0] cnt_q;
	logic [7:0] op_q;
	logic [7:0] b1_q;
	cal_cls_t cls_q;
	logic [PC_W-1:0] pc_q;
	logic [PC_W-1:0] tgt_q;
	logic [7:0] sreg_q [4];
	logic [2:0] sp_q;
	logic [PC_W-1:0] top_w;
	logic [2:0] top_idx;

	// Opcode to class decode; arithmetic codes are not in this block and act as no-ops.
	function automatic cal_cls_t decode(input logic [7:0] op);
		cal_cls_t c;
		c = CLS_NOP;
		if (!op[7]) begin
			c = CLS_BR;
		end else if (op[7:5] == OPG_IND) begin
			c = CLS_IND;
		end else begin
			case (op[7:4])
				OPG_SHORT: c = CLS_SHORT;
				OPG_JUMP: c = CLS_JUMP;
				OPG_CALL: c = CLS_CALL;
				OPG_BIT: c = CLS_BIT;
				OPG_BTB: c = CLS_BTB;
				OPG_MISC: begin
					case (op[3:0])
						SUB_DLOAD: c = CLS_DLOAD;
						SUB_DSTORE: c = CLS_DSTORE;
						SUB_LDI_ACC: c = CLS_LDI_ACC;
						SUB_LDI_MEM: c = CLS_LDI_MEM;
						SUB_RET: c = CLS_RET;
						default: c = CLS_NOP;
					endcase
				end
				default: c = CLS_NOP;
			endcase
		end
		return c;
	endfunction : decode

	// Cycles each class occupies.
	function automatic logic [2:0] cycles(input cal_cls_t c);
		logic [2:0] n;
		case (c)
			CLS_BR: n = CYC_BR;
			CLS_RET, CLS_NOP: n = CYC_CTL;
			CLS_BTB: n = CYC_BTB;
			CLS_BIT: n = CYC_BIT;
			CLS_JUMP, CLS_CALL: n = CYC_JMP;
			default: n = CYC_LS;
		endcase
		return n;
	endfunction : cycles

	// Instruction length in bytes.
	function automatic logic [PC_W-1:0] length(input cal_cls_t c);
		logic [PC_W-1:0] n;
		case (c)
			CLS_LDI_MEM, CLS_BTB: n = 12'h003;
			CLS_DLOAD, CLS_DSTORE, CLS_LDI_ACC, CLS_BIT, CLS_JUMP, CLS_CALL: n = 12'h002;
			default: n = 12'h001;
		endcase
		return n;
	endfunction : length

	// Locations 80h..83h and the accumulator are held inside the core.
	function automatic logic is_internal(input logic [7:0] a);
		return (a[7:2] == ADDR_SHORT_BASE[7:2]) || (a == ADDR_ACC);
	endfunction : is_internal

	// The opcode is on the program bus during cycle 1 and held afterwards.
	logic [7:0] op_w;
	cal_cls_t cls_w;
	logic last_w;
	assign op_w = (cnt_q == 3'h1) ? pm_rdata : op_q;
	assign cls_w = (cnt_q == 3'h1) ? decode(pm_rdata) : cls_q;
	assign last_w = (cnt_q != 3'h0) && (cnt_q == cycles(cls_w) - 3'h1);

	// Read data of the data space: internal registers or external memory.
	logic [7:0] rd_w;
	always_comb begin
		rd_w = dm_rdata;
		if (dm_req_q.addr == ADDR_ACC) begin
			rd_w = acc_q;
		end else if (dm_req_q.addr[7:2] == ADDR_SHORT_BASE[7:2]) begin
			rd_w = sreg_q[dm_req_q.addr[1:0]];
		end
	end

	// Data-space actions of the current cycle.
	logic ra_en;
	logic [7:0] ra_addr;
	logic wr_en;
	logic [7:0] wr_addr;
	logic [7:0] wr_data;
	logic ld_en;
	logic [7:0] ld_data;
	logic z_en;
	logic [7:0] z_byte;
	logic c_en;
	logic c_val;
	always_comb begin
		ra_en = 1'b0;
		ra_addr = 8'h00;
		wr_en = 1'b0;
		wr_addr = 8'h00;
		wr_data = 8'h00;
		ld_en = 1'b0;
		ld_data = 8'h00;
		z_en = 1'b0;
		z_byte = 8'h00;
		c_en = 1'b0;
		c_val = 1'b0;
		case (cls_w)
			CLS_SHORT: begin
				if (cnt_q == 3'h1) begin
					z_en = 1'b1;
					if (op_w[3]) begin
						wr_en = 1'b1;
						wr_addr = ADDR_SHORT_BASE | {6'h00, op_w[1:0]};
						wr_data = acc_q;
						z_byte = acc_q;
					end else begin
						ld_en = 1'b1;
						ld_data = sreg_q[op_w[1:0]];
						z_byte = ld_data;
					end
				end
			end
			CLS_DLOAD: begin
				if (cnt_q == 3'h2) begin
					ra_en = 1'b1;
					ra_addr = pm_rdata;
				end else if (cnt_q == 3'h3) begin
					ld_en = 1'b1;
					ld_data = rd_w;
					z_en = 1'b1;
					z_byte = rd_w;
				end
			end
			CLS_DSTORE: begin
				if (cnt_q == 3'h2) begin
					wr_en = 1'b1;
					wr_addr = pm_rdata;
					wr_data = acc_q;
					z_en = 1'b1;
					z_byte = acc_q;
				end
			end
			CLS_IND: begin
				if (cnt_q == 3'h1) begin
					if (op_w[0]) begin
						wr_en = 1'b1;
						wr_addr = sreg_q[{1'b0, op_w[4]}];
						wr_data = acc_q;
						z_en = 1'b1;
						z_byte = acc_q;
					end else begin
						ra_en = 1'b1;
						ra_addr = sreg_q[{1'b0, op_w[4]}];
					end
				end else if (cnt_q == 3'h2 && !op_w[0]) begin
					ld_en = 1'b1;
					ld_data = rd_w;
					z_en = 1'b1;
					z_byte = rd_w;
				end
			end
			CLS_LDI_ACC: begin
				if (cnt_q == 3'h2) begin
					ld_en = 1'b1;
					ld_data = pm_rdata;
					z_en = 1'b1;
					z_byte = pm_rdata;
				end
			end
			CLS_LDI_MEM: begin
				if (cnt_q == 3'h3) begin
					wr_en = 1'b1;
					wr_addr = b1_q;
					wr_data = pm_rdata;
				end
			end
			CLS_BIT: begin
				if (cnt_q == 3'h2) begin
					ra_en = 1'b1;
					ra_addr = pm_rdata;
				end else if (cnt_q == 3'h3) begin
					c_en = 1'b1;
					c_val = rd_w[op_w[2:0]];
					wr_en = 1'b1;
					wr_addr = dm_req_q.addr;
					wr_data = rd_w;
					wr_data[op_w[2:0]] = op_w[3];
				end
			end
			CLS_BTB: begin
				if (cnt_q == 3'h2) begin
					ra_en = 1'b1;
					ra_addr = pm_rdata;
				end else if (cnt_q == 3'h3) begin
					c_en = 1'b1;
					c_val = rd_w[op_w[2:0]];
				end
			end
			default: begin
			end
		endcase
	end

	// Sequencing: cycle count, opcode, first operand byte and retire pulse.
	always_ff @(posedge clock) begin
		if (rst) begin
			cnt_q <= 3'h0;
			op_q <= 8'h00;
			b1_q <= 8'h00;
			cls_q <= CLS_NOP;
			retire_q <= 1'b0;
		end else if (ce) begin
			cnt_q <= last_w ? 3'h0 : cnt_q + 3'h1;
			retire_q <= last_w;
			if (cnt_q == 3'h1) begin
				op_q <= pm_rdata;
				cls_q <= decode(pm_rdata);
			end
			if (cnt_q == 3'h2) begin
				b1_q <= pm_rdata;
			end
		end
	end

	// Relative branch condition and targets.
	logic br_true;
	logic [PC_W-1:0] span_w;
	logic [PC_W-1:0] rel_tgt;
	logic [PC_W-1:0] btb_tgt;
	always_comb begin
		case (op_w[6:5])
			COND_NZ: br_true = !flags_q.zero;
			COND_NC: br_true = !flags_q.carry;
			COND_Z: br_true = flags_q.zero;
			default: br_true = flags_q.carry;
		endcase
		span_w = {8'h00, op_w[3:0]};
		rel_tgt = op_w[4] ? pc_q - span_w : pc_q + 12'h001 + span_w;
		btb_tgt = pc_q + 12'h001 + {{4{pm_rdata[7]}}, pm_rdata};
	end

	// Next instruction address, chosen in the last cycle.
	logic [PC_W-1:0] npc_w;
	always_comb begin
		npc_w = pc_q + length(cls_w);
		case (cls_w)
			CLS_BR: npc_w = br_true ? rel_tgt : pc_q + 12'h001;
			CLS_JUMP, CLS_CALL, CLS_BTB: npc_w = tgt_q;
			CLS_RET: npc_w = top_w;
			default: npc_w = pc_q + length(cls_w);
		endcase
	end

	// Program counter, branch target and program memory address.
	always_ff @(posedge clock) begin
		if (rst) begin
			pc_q <= RESET_PC;
			tgt_q <= RESET_PC;
			pm_addr_q <= RESET_PC;
		end else if (ce) begin
			if (last_w) begin
				pc_q <= npc_w;
				pm_addr_q <= npc_w;
			end else begin
				pm_addr_q <= pc_q + {9'h000, cnt_q} + 12'h001;
			end
			if (cnt_q == 3'h2) begin
				tgt_q <= {op_w[3:0], pm_rdata};
			end
			if (cls_w == CLS_BTB && cnt_q == 3'h3) begin
				tgt_q <= (rd_w[op_w[2:0]] == op_w[3]) ? btb_tgt : pc_q + 12'h003;
			end
		end
	end

	// Data-space port, accumulator, short registers and flags.
	always_ff @(posedge clock) begin
		if (rst) begin
			dm_req_q <= '0;
			acc_q <= 8'h00;
			sreg_q <= '{default: 8'h00};
			flags_q <= '0;
		end else if (ce) begin
			dm_req_q.we <= 1'b0;
			if (ra_en) begin
				dm_req_q.addr <= ra_addr;
			end
			if (wr_en) begin
				dm_req_q.addr <= wr_addr;
				dm_req_q.wdata <= wr_data;
				dm_req_q.we <= !is_internal(wr_addr);
				if (wr_addr == ADDR_ACC) begin
					acc_q <= wr_data;
				end else if (wr_addr[7:2] == ADDR_SHORT_BASE[7:2]) begin
					sreg_q[wr_addr[1:0]] <= wr_data;
				end
			end
			if (ld_en) begin
				acc_q <= ld_data;
			end
			if (z_en) begin
				flags_q.zero <= (z_byte == 8'h00);
			end
			if (c_en) begin
				flags_q.carry <= c_val;
			end
		end
	end

	// Return stack pointer; the cells wrap round when more than six are pushed.
	logic push_w;
	assign push_w = (cls_w == CLS_CALL) && (cnt_q == 3'h2);
	assign top_idx = (sp_q == 3'h0) ? 3'(STACK_DEPTH - 1) : sp_q - 3'h1;
	always_ff @(posedge clock) begin
		if (rst) begin
			sp_q <= 3'h0;
		end else if (ce) begin
			if (push_w) begin
				sp_q <= (sp_q == 3'(STACK_DEPTH - 1)) ? 3'h0 : sp_q + 3'h1;
			end else if (cls_w == CLS_RET && last_w) begin
				sp_q <= top_idx;
			end
		end
	end

	cal_stack_mem #(
		.DEPTH(STACK_DEPTH),
		.WIDTH(PC_W)
	) u_stack (
		.clock(clock),
		.ce(ce),
		.we(push_w),
		.waddr(sp_q),
		.wdata(pc_q + 12'h002),
		.raddr(top_idx),
		.rdata(top_w)
	);
endmodule : cal_core
`default_nettype wire

/* File: cal_core_sva.sv */
`default_nettype none
module cal_core_sva (
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	input wire logic [7:0] pm_rdata,
	input wire logic [cal_pkg::PC_W-1:0] pm_addr_q,
	input wire logic [7:0] dm_rdata,
	input wire cal_pkg::cal_dm_req_t dm_req_q,
	input wire logic [7:0] acc_q,
	input wire cal_pkg::cal_flags_t flags_q,
	input wire logic retire_q
);
	timeunit 1ns;
	timeprecision 1ps;
	import cal_pkg::*;
	logic first_q;
	logic op_q;
	logic ls;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// Tracks the cycle in which the program byte is an opcode.
	always_ff @(posedge clock) begin
		if (rst) begin
			first_q <= 1'b1;
			op_q <= 1'b0;
		end else if (ce) begin
			first_q <= 1'b0;
			op_q <= first_q | retire_q;
		end
	end
	// Opcode belongs to the load and store group.
	assign ls = op_q && (pm_rdata[7:5] == OPG_IND || pm_rdata[7:4] == OPG_SHORT
		|| (pm_rdata[7:4] == OPG_MISC && pm_rdata[3:0] < 4'h4));
	property p_we_ext;
		dm_req_q.we |-> dm_req_q.addr[7:2] != 6'h20 && dm_req_q.addr != 8'hff;
	endproperty
	a_we_ext: assert property (p_we_ext) else $error("write to core location");
	property p_ret;
		ce && retire_q |=> !retire_q;
	endproperty
	a_ret: assert property (p_ret) else $error("retire too long");
	property p_hold;
		!ce |=> $stable(pm_addr_q) && $stable(acc_q) && $stable(flags_q);
	endproperty
	a_hold: assert property (p_hold) else $error("state moved while frozen");
	property p_ls_cyc;
		ls |=> !retire_q ##1 !retire_q ##1 retire_q;
	endproperty
	a_ls_cyc: assert property (p_ls_cyc) else $error("load length");
	property p_ldi_acc;
		op_q && pm_rdata == 8'he2 |=> ##2 acc_q == $past(pm_rdata, 2) && flags_q.zero == (acc_q == 8'h00);
	endproperty
	a_ldi_acc: assert property (p_ldi_acc) else $error("immediate load");
	property p_carry;
		ls |-> ##3 flags_q.carry == $past(flags_q.carry, 3);
	endproperty
	a_carry: assert property (p_carry) else $error("carry changed");
	property p_ldi_mem;
		op_q && pm_rdata == 8'he3 |-> ##3 flags_q == $past(flags_q, 3);
	endproperty
	a_ldi_mem: assert property (p_ldi_mem) else $error("flags changed");
	property p_store;
		op_q && pm_rdata == 8'he1 |=> ##1 dm_req_q.addr == $past(pm_rdata) && dm_req_q.wdata == acc_q
			&& dm_req_q.we == ($past(pm_rdata[7:2]) != 6'h20 && $past(pm_rdata) != 8'hff);
	endproperty
	a_store: assert property (p_store) else $error("direct store");
endmodule : cal_core_sva
bind cal_core cal_core_sva i_cal_core_sva (.clock(clock), .rst(rst), .ce(ce), .pm_rdata(pm_rdata),
	.pm_addr_q(pm_addr_q), .dm_rdata(dm_rdata), .dm_req_q(dm_req_q), .acc_q(acc_q), .flags_q(flags_q),
	.retire_q(retire_q));
`default_nettype wire

/* File: cal_mem_model.sv */
`default_nettype none
module cal_mem_model (
	input wire logic clock,
	input wire logic [cal_pkg::PC_W-1:0] pm_addr_q,
	output logic [7:0] pm_rdata,
	input wire cal_pkg::cal_dm_req_t dm_req_q,
	output logic [7:0] dm_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	import cal_pkg::*;
	logic [7:0] prog [0:4095];
	logic [7:0] data [0:255];
	// Unused program bytes are two-cycle no-operations.
	initial begin
		foreach (prog[i]) prog[i] = 8'he5;
		foreach (data[i]) data[i] = 8'h00;
	end
	// Program bytes answer one cycle after the address.
	always @(posedge clock) pm_rdata <= prog[pm_addr_q];
	// Data bytes are written on the strobe and read at once.
	always @(posedge clock) if (dm_req_q.we) data[dm_req_q.addr] <= dm_req_q.wdata;
	assign dm_rdata = data[dm_req_q.addr];
endmodule : cal_mem_model
`default_nettype wire

/* File: testbench.sv */
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import cal_pkg::*;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic [7:0] pm_rdata;
	logic [PC_W-1:0] pm_addr_q;
	logic [7:0] dm_rdata;
	cal_dm_req_t dm_req_q;
	logic [7:0] acc_q;
	cal_flags_t flags_q;
	logic retire_q;
	int errors = 0;
	int comparisons = 0;
	cal_core i_cal_core (.clock(clock), .rst(rst), .ce(ce), .pm_rdata(pm_rdata), .pm_addr_q(pm_addr_q),
		.dm_rdata(dm_rdata), .dm_req_q(dm_req_q), .acc_q(acc_q), .flags_q(flags_q), .retire_q(retire_q));
	cal_mem_model i_cal_mem_model (.clock(clock), .pm_addr_q(pm_addr_q), .pm_rdata(pm_rdata),
		.dm_req_q(dm_req_q), .dm_rdata(dm_rdata));
	// The 100 MHz clock.
	initial begin
		forever #5 clock = ~clock;
	end
	task automatic end_sim;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_sim
	task automatic chk_v(input logic [11:0] got, input logic [11:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_v
	// Writes four program bytes, first byte at the lowest address.
	task automatic put(input logic [11:0] a, input logic [31:0] b);
		for (int i = 0; i < 4; i++) i_cal_mem_model.prog[a + 12'(i)] = b[31 - 8 * i -: 8];
	endtask : put
	// Holds reset for three cycles.
	task automatic boot;
		@(negedge clock);
		rst = 1'b1;
		repeat (3) @(negedge clock);
		rst = 1'b0;
	endtask : boot
	// Waits for the next retire and compares the core state; a zero count skips the length.
	task automatic step(input logic [11:0] pc, input logic [7:0] acc, input logic z, input logic c,
		input logic [11:0] cy);
		logic [11:0] n;
		n = 12'h000;
		do begin
			@(negedge clock);
			n++;
		end while (retire_q !== 1'b1 && n < 12'h040);
		if (n == 12'h040) begin
			errors++;
			end_sim;
		end
		chk_v(pm_addr_q, pc);
		chk_v({4'h0, acc_q}, {4'h0, acc});
		chk_v({10'h000, flags_q}, {10'h000, z, c});
		if (cy != 12'h000) chk_v(n, cy);
	endtask : step
	// Loads and stores in the immediate, direct and indirect modes and short stores, framed by bit clear and set.
	task automatic t_loads;
		put(12'h000, 32'ha050e200);
		put(12'h004, 32'he140e25a);
		put(12'h008, 32'he141e342);
		put(12'h00c, 32'h3ce04088);
		put(12'h010, 32'hc089d1a8);
		put(12'h014, 32'h50e5e5e5);
		i_cal_mem_model.data[8'h50] = 8'h01;
		i_cal_mem_model.data[8'h00] = 8'h77;
		boot;
		chk_v(pm_addr_q, 12'h000);
		chk_v({2'h0, acc_q, flags_q}, 12'h000);
		step(12'h002, 8'h00, 1'b0, 1'b1, 12'h004);
		step(12'h004, 8'h00, 1'b1, 1'b1, 12'h004);
		step(12'h006, 8'h00, 1'b1, 1'b1, 12'h004);
		step(12'h008, 8'h5a, 1'b0, 1'b1, 12'h004);
		step(12'h00a, 8'h5a, 1'b0, 1'b1, 12'h004);
		step(12'h00d, 8'h5a, 1'b0, 1'b1, 12'h004);
		step(12'h00f, 8'h00, 1'b1, 1'b1, 12'h004);
		step(12'h010, 8'h00, 1'b1, 1'b1, 12'h004);
		step(12'h011, 8'h77, 1'b0, 1'b1, 12'h004);
		step(12'h012, 8'h77, 1'b0, 1'b1, 12'h004);
		step(12'h013, 8'h77, 1'b0, 1'b1, 12'h004);
		step(12'h015, 8'h77, 1'b0, 1'b0, 12'h004);
		step(12'h016, 8'h77, 1'b0, 1'b0, 12'h002);
		chk_v({4'h0, i_cal_mem_model.data[8'h40]}, 12'h000);
		chk_v({4'h0, i_cal_mem_model.data[8'h41]}, 12'h05a);
		chk_v({4'h0, i_cal_mem_model.data[8'h42]}, 12'h03c);
		chk_v({4'h0, i_cal_mem_model.data[8'h77]}, 12'h077);
		chk_v({4'h0, i_cal_mem_model.data[8'h50]}, 12'h001);
	endtask : t_loads
	// Relative branches at both span ends and a long jump.
	task automatic t_branch;
		put(12'h000, 32'he20043e2);
		put(12'h004, 32'h22e2639f);
		put(12'h008, 32'h00e5e5e5);
		put(12'hefb, 32'h4fe200e5);
		put(12'hf00, 32'h35e5e5e5);
		put(12'hf0b, 32'h3fe5e5e5);
		boot;
		step(12'h002, 8'h00, 1'b1, 1'b0, 12'h004);
		step(12'h006, 8'h00, 1'b1, 1'b0, 12'h002);
		step(12'h007, 8'h00, 1'b1, 1'b0, 12'h002);
		step(12'hf00, 8'h00, 1'b1, 1'b0, 12'h004);
		step(12'hefb, 8'h00, 1'b1, 1'b0, 12'h002);
		step(12'hf0b, 8'h00, 1'b1, 1'b0, 12'h002);
		step(12'hefc, 8'h00, 1'b1, 1'b0, 12'h002);
		step(12'hefe, 8'h00, 1'b1, 1'b0, 12'h004);
	endtask : t_branch
	// Bit test branches taken, at the far displacement and not taken, then a frozen jump.
	task automatic t_bits;
		put(12'h000, 32'hb85010e5);
		put(12'h011, 32'hb15080e5);
		put(12'hf92, 32'hb851059f);
		put(12'hf96, 32'h00e5e5e5);
		boot;
		step(12'h011, 8'h00, 1'b0, 1'b1, 12'h005);
		step(12'hf92, 8'h00, 1'b0, 1'b0, 12'h005);
		step(12'hf95, 8'h00, 1'b0, 1'b0, 12'h005);
		ce = 1'b0;
		repeat (3) @(negedge clock);
		chk_v(pm_addr_q, 12'hf95);
		ce = 1'b1;
		step(12'hf00, 8'h00, 1'b0, 1'b0, 12'h004);
	endtask : t_bits
	// Short store and load, a call, a taken not-zero branch and the return.
	task automatic t_calls;
		put(12'h000, 32'he23c89e2);
		put(12'h004, 32'h00f100e5);
		put(12'h100, 32'h8102e5e5);
		put(12'h104, 32'he4e5e5e5);
		boot;
		step(12'h002, 8'h3c, 1'b0, 1'b0, 12'h004);
		step(12'h003, 8'h3c, 1'b0, 1'b0, 12'h004);
		step(12'h005, 8'h00, 1'b1, 1'b0, 12'h004);
		step(12'h100, 8'h00, 1'b1, 1'b0, 12'h004);
		step(12'h101, 8'h3c, 1'b0, 1'b0, 12'h004);
		step(12'h104, 8'h3c, 1'b0, 1'b0, 12'h002);
		step(12'h007, 8'h3c, 1'b0, 1'b0, 12'h002);
		step(12'h008, 8'h3c, 1'b0, 1'b0, 12'h002);
	endtask : t_calls
	// Main sequence.
	initial begin
		t_loads;
		t_branch;
		t_bits;
		t_calls;
		end_sim;
	end
endmodule : testbench
`default_nettype wire
